// file: src/dsl_defs.vh
// Constants for the lane-configuration control block.
// Assumes a 25 MHz clock; included by bare name.
// Function
// - Capture AUX writes to lane-count, power-state addresses
// - Snoop active: enable lanes from captured count
// - Snoop active: power state D3 disables all lanes
// - Snooping on after reset; disable bit
// - Snoop off in I2C: lanes from config
// - Interface strap level 0 selects GPIO mode
// - GPIO snoop-disable pin high: four lanes active
// - GPIO link-enable pin gates whole path
// - Other strap levels select I2C register mode
// - Straps decode low, R, F, high as 0-3
// - Straps captured at internal reset release
// - Bias resistors isolated after hold interval
// - GPIO equalization index is 4*upper plus lower
// - I2C mode: separate per-lane equalization index
// - Power-good within 500 us of supply
// - Debounce falling link-enable and hot-plug inputs
`ifndef DSL_DEFS_VH
`define DSL_DEFS_VH
`define DSL_CLK_MHZ 25
`define DSL_ADDR_LANE_COUNT 20'h00101
`define DSL_ADDR_POWER_STATE 20'h00600
`define DSL_LANE_MASK_1 4'h1
`define DSL_LANE_MASK_2 4'h3
`define DSL_LANE_MASK_4 4'hf
`define DSL_LANES_ALL 4'hf
`define DSL_LANES_NONE 4'h0
`define DSL_CNT_1 5'h01
`define DSL_CNT_2 5'h02
`define DSL_CNT_4 5'h04
`define DSL_CNT_FIELD 4:0
`define DSL_PWR_FIELD 2:0
`define DSL_PWR_D3 3'h2
`define DSL_PWR_D0 3'h1
`define DSL_LVL_LOW 2'h0
`define DSL_LVL_R 2'h1
`define DSL_LVL_F 2'h2
`define DSL_LVL_HIGH 2'h3
`define DSL_HOLD_US 10
`define DSL_PG_US 500
`define DSL_DEBOUNCE_MS 2
`endif

// file: src/dsl_strap_sync.v
// Three-stage synchroniser with agreement filter for W pins.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module dsl_strap_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk,
  input wire sys_rst,
  input wire [W-1:0] pin,
  output reg [W-1:0] level
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  // Second and third stage must agree before level moves
  always @(posedge clk) begin
    if (sys_rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule // dsl_strap_sync
`default_nettype wire

// file: src/dsl_lane_ctrl.v
// Lane enable and equalization control for a four-lane redriver.
// Assumes an AUX decoder supplies completed transactions and strap
// comparators supply two-bit levels (0 low, 1 R, 2 F, 3 high).
`timescale 1ns/1ns
`default_nettype none
`include "dsl_defs.vh"
module dsl_lane_ctrl #(
  parameter integer HOLD_CYCLES = `DSL_HOLD_US * `DSL_CLK_MHZ,
  parameter integer PG_CYCLES = `DSL_PG_US * `DSL_CLK_MHZ,
  parameter integer DEBOUNCE_CYCLES = `DSL_DEBOUNCE_MS * 1000 * `DSL_CLK_MHZ
) (
  input wire clk,
  input wire sys_rst,
  input wire aux_valid,
  input wire aux_is_write,
  input wire aux_acked,
  input wire [19:0] aux_addr,
  input wire [7:0] aux_data,
  input wire [1:0] if_sel_strap,
  input wire [1:0] addr_strap_low,
  input wire [3:0] eq_strap_pair,
  input wire snoop_disable_pin,
  input wire link_enable_pin,
  input wire hot_plug_input,
  input wire cfg_snoop_disable,
  input wire cfg_link_enable,
  input wire [3:0] cfg_lane_enable,
  input wire [3:0] cfg_lane0_eq,
  input wire [3:0] cfg_lane1_eq,
  input wire [3:0] cfg_lane2_eq,
  input wire [3:0] cfg_lane3_eq,
  output reg power_good,
  output reg strap_captured,
  output reg bias_enable,
  output reg i2c_mode,
  output reg [1:0] addr_level_low,
  output reg [1:0] addr_level_high,
  output reg snoop_active,
  output reg [4:0] lane_count_cap,
  output reg [2:0] power_state_cap,
  output reg hot_plug_level,
  output reg link_enabled,
  output reg [3:0] lane_enable,
  output reg [3:0] lane0_eq_index,
  output reg [3:0] lane1_eq_index,
  output reg [3:0] lane2_eq_index,
  output reg [3:0] lane3_eq_index
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Combine two strap levels into an equalization index
  function [3:0] eq_index;
    input [1:0] upper;
    input [1:0] lower;
    begin
      eq_index = {upper, lower};
    end
  endfunction

  // Lane mask for a captured count, or previous mask if unsupported
  function [3:0] lane_mask;
    input [4:0] cnt;
    input [3:0] prev;
    begin
      case (cnt)
        `DSL_CNT_1: lane_mask = `DSL_LANE_MASK_1;
        `DSL_CNT_2: lane_mask = `DSL_LANE_MASK_2;
        `DSL_CNT_4: lane_mask = `DSL_LANE_MASK_4;
        default: lane_mask = prev;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire [1:0] if_sel_sync;
  wire [1:0] addr_sync;
  wire [3:0] eq_sync;
  wire snoop_pin_sync;
  wire link_pin_sync;
  wire hpd_pin_sync;

  dsl_strap_sync #(.W(10), .INIT(10'h000)) u_strap_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin({if_sel_strap, addr_strap_low, eq_strap_pair}),
    .level({if_sel_sync, addr_sync, eq_sync})
  );

  dsl_strap_sync #(.W(3), .INIT(3'h0)) u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin({snoop_disable_pin, link_enable_pin, hot_plug_input}),
    .level({snoop_pin_sync, link_pin_sync, hpd_pin_sync})
  );

  ////////////////////////////////////////////////////////////////////
  // Power-good and internal reset release

  reg [31:0] pg_cnt;
  reg [31:0] hold_cnt;
  reg [3:0] eq_strap_cap;

  // Power-good asserts after a fixed delay from reset
  always @(posedge clk) begin
    if (sys_rst) begin
      pg_cnt <= 32'h0000_0000;
      power_good <= 1'b0;
    end else if (!power_good) begin
      if (pg_cnt >= PG_CYCLES - 1) begin
        power_good <= 1'b1;
      end else begin
        pg_cnt <= pg_cnt + 32'h0000_0001;
      end
    end
  end

  // Straps captured on internal reset release, bias dropped after hold
  always @(posedge clk) begin
    if (sys_rst) begin
      strap_captured <= 1'b0;
      bias_enable <= 1'b1;
      hold_cnt <= 32'h0000_0000;
      i2c_mode <= 1'b0;
      addr_level_low <= `DSL_LVL_LOW;
      addr_level_high <= `DSL_LVL_LOW;
      eq_strap_cap <= 4'h0;
    end else if (power_good && !strap_captured) begin
      strap_captured <= 1'b1;
      i2c_mode <= (if_sel_sync != `DSL_LVL_LOW);
      addr_level_low <= addr_sync;
      addr_level_high <= eq_sync[1:0];
      eq_strap_cap <= eq_sync;
    end else if (strap_captured && bias_enable) begin
      if (hold_cnt >= HOLD_CYCLES - 1) begin
        bias_enable <= 1'b0;
      end else begin
        hold_cnt <= hold_cnt + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Debounce of link-enable and hot-plug falling edges

  reg [31:0] link_db_cnt;
  reg [31:0] hpd_db_cnt;
  reg link_db;

  // Rising edges pass at once; falls must persist
  always @(posedge clk) begin
    if (sys_rst) begin
      link_db <= 1'b0;
      hot_plug_level <= 1'b0;
      link_db_cnt <= 32'h0000_0000;
      hpd_db_cnt <= 32'h0000_0000;
    end else begin
      if (link_pin_sync || !link_db) begin
        link_db <= link_pin_sync;
        link_db_cnt <= 32'h0000_0000;
      end else if (link_db_cnt >= DEBOUNCE_CYCLES - 1) begin
        link_db <= 1'b0;
      end else begin
        link_db_cnt <= link_db_cnt + 32'h0000_0001;
      end
      if (hpd_pin_sync || !hot_plug_level) begin
        hot_plug_level <= hpd_pin_sync;
        hpd_db_cnt <= 32'h0000_0000;
      end else if (hpd_db_cnt >= DEBOUNCE_CYCLES - 1) begin
        hot_plug_level <= 1'b0;
      end else begin
        hpd_db_cnt <= hpd_db_cnt + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AUX snooping

  reg [3:0] snoop_mask;
  reg next_snoop_active;

  // Snoop source: pin in GPIO mode, control bit in I2C mode
  always @* begin
    next_snoop_active = i2c_mode ? !cfg_snoop_disable : !snoop_pin_sync;
  end

  // Capture acknowledged native writes to the two DPCD addresses
  always @(posedge clk) begin
    if (sys_rst) begin
      snoop_active <= 1'b1;
      lane_count_cap <= `DSL_CNT_4;
      power_state_cap <= `DSL_PWR_D0;
      snoop_mask <= `DSL_LANES_ALL;
    end else begin
      snoop_active <= strap_captured ? next_snoop_active : 1'b1;
      if (snoop_active && aux_valid && aux_is_write && aux_acked) begin
        if (aux_addr == `DSL_ADDR_LANE_COUNT) begin
          lane_count_cap <= aux_data[`DSL_CNT_FIELD];
          snoop_mask <= lane_mask(aux_data[`DSL_CNT_FIELD], snoop_mask);
        end
        if (aux_addr == `DSL_ADDR_POWER_STATE) begin
          power_state_cap <= aux_data[`DSL_PWR_FIELD];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Lane enables and equalization outputs

  reg [3:0] next_lane_enable;
  reg next_link_enabled;

  // Select lane set by mode, snoop state and power state
  always @* begin
    next_link_enabled = i2c_mode ? cfg_link_enable : link_db;
    if (!next_link_enabled) begin
      next_lane_enable = `DSL_LANES_NONE;
    end else if (snoop_active) begin
      if (power_state_cap == `DSL_PWR_D3) begin
        next_lane_enable = `DSL_LANES_NONE;
      end else begin
        next_lane_enable = snoop_mask;
      end
    end else if (i2c_mode) begin
      next_lane_enable = cfg_lane_enable;
    end else begin
      next_lane_enable = `DSL_LANES_ALL;
    end
  end

  // Registered outputs; GPIO uses strap index on all lanes
  always @(posedge clk) begin
    if (sys_rst) begin
      link_enabled <= 1'b0;
      lane_enable <= `DSL_LANES_NONE;
      lane0_eq_index <= 4'h0;
      lane1_eq_index <= 4'h0;
      lane2_eq_index <= 4'h0;
      lane3_eq_index <= 4'h0;
    end else if (strap_captured) begin
      link_enabled <= next_link_enabled;
      lane_enable <= next_lane_enable;
      if (i2c_mode) begin
        lane0_eq_index <= cfg_lane0_eq;
        lane1_eq_index <= cfg_lane1_eq;
        lane2_eq_index <= cfg_lane2_eq;
        lane3_eq_index <= cfg_lane3_eq;
      end else begin
        lane0_eq_index <= eq_index(eq_strap_cap[3:2], eq_strap_cap[1:0]);
        lane1_eq_index <= eq_index(eq_strap_cap[3:2], eq_strap_cap[1:0]);
        lane2_eq_index <= eq_index(eq_strap_cap[3:2], eq_strap_cap[1:0]);
        lane3_eq_index <= eq_index(eq_strap_cap[3:2], eq_strap_cap[1:0]);
      end
    end
  end

endmodule // dsl_lane_ctrl
`default_nettype wire

// file: verif/dsl_lane_sva.sv
// Checker on the lane-control ports.
// Assumes HOLD_CYCLES of 5 and straps held from reset.
`timescale 1ns/1ns
`default_nettype none
module dsl_lane_sva (
  input wire clk,
  input wire sys_rst,
  input wire aux_valid,
  input wire aux_is_write,
  input wire aux_acked,
  input wire [19:0] aux_addr,
  input wire [7:0] aux_data,
  input wire [3:0] eq_strap_pair,
  input wire [3:0] cfg_lane0_eq,
  input wire [3:0] cfg_lane3_eq,
  input wire strap_captured,
  input wire bias_enable,
  input wire i2c_mode,
  input wire snoop_active,
  input wire [4:0] lane_count_cap,
  input wire [2:0] power_state_cap,
  input wire link_enabled,
  input wire [3:0] lane_enable,
  input wire [3:0] lane0_eq_index,
  input wire [3:0] lane3_eq_index
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Write that the snooper should take
  wire wr = aux_valid && aux_is_write && aux_acked && snoop_active;
  ////////////////////////////////////////
  a_count_capture: assert property (wr && aux_addr == 20'h00101 |=> lane_count_cap == $past(aux_data[4:0]))
    else $error("lane count not captured");
  a_power_capture: assert property (wr && aux_addr == 20'h00600 |=> power_state_cap == $past(aux_data[2:0]))
    else $error("power state not captured");
  a_junk_ignored: assert property (aux_valid && !(aux_is_write && aux_acked)
    |=> $stable(lane_count_cap) && $stable(power_state_cap)) else $error("read or nak changed capture");
  a_d3_dark: assert property ((snoop_active && power_state_cap == 3'h2) [*2] |-> lane_enable == 4'h0)
    else $error("lanes on in D3");
  a_two_lanes: assert property ((snoop_active && link_enabled && power_state_cap != 3'h2
    && lane_count_cap == 5'h02) [*2] |-> lane_enable == 4'h3) else $error("count two mask");
  a_gpio_all_on: assert property ((strap_captured && !i2c_mode && !snoop_active && link_enabled) [*2]
    |-> lane_enable == 4'hf) else $error("snoop off not all lanes");
  a_link_dark: assert property ((!link_enabled) [*2] |-> lane_enable == 4'h0) else $error("lanes on, link off");
  a_gpio_eq: assert property ((strap_captured && !i2c_mode) [*2]
    |-> lane0_eq_index == eq_strap_pair && lane3_eq_index == eq_strap_pair) else $error("gpio eq");
  a_i2c_eq: assert property ((strap_captured && i2c_mode && $stable(cfg_lane0_eq) && $stable(cfg_lane3_eq)) [*3]
    |-> lane0_eq_index == cfg_lane0_eq && lane3_eq_index == cfg_lane3_eq) else $error("i2c eq");
  a_snoop_default: assert property (!strap_captured |-> snoop_active && bias_enable)
    else $error("pre-capture state");
  a_bias_drop: assert property ($rose(strap_captured) |-> bias_enable [*4] ##[1:8] !bias_enable)
    else $error("bias hold");
  a_mode_latched: assert property (strap_captured && $past(strap_captured) |=> $stable(i2c_mode))
    else $error("mode changed");
endmodule // dsl_lane_sva
bind dsl_lane_ctrl dsl_lane_sva u_sva (.*);
`default_nettype wire

// file: verif/dsl_aux_peer.sv
// Source and sink pair presenting completed AUX transactions.
// Assumes one transaction per pulse, driven off the falling edge.
`timescale 1ns/1ns
`default_nettype none
module dsl_aux_peer (
  input wire clk,
  output logic valid,
  output logic is_write,
  output logic acked,
  output logic [19:0] addr,
  output logic [7:0] data
);
  // Idle bus
  initial begin
    valid = 1'h0;
    {is_write, acked, addr, data} = 30'h0;
  end
  // One-cycle transaction, then stale lines inverted
  task automatic xfer(input logic w, input logic k, input logic [19:0] a, input logic [7:0] d);
    @(negedge clk);
    valid = 1'h1;
    {is_write, acked, addr, data} = {w, k, a, d};
    @(negedge clk);
    valid = 1'h0;
    {is_write, acked, addr, data} = ~{w, k, a, d};
  endtask
endmodule // dsl_aux_peer
`default_nettype wire

// file: verif/tb.sv
// Bench for the lane-control block.
// Assumes shortened counts: PG 10, hold 5, debounce 20.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [1:0] sel = 2'h0;
  logic [3:0] eqs = 4'h9;
  logic snp = 1'h0, lnk = 1'h1, hpd = 1'h1, csnp = 1'h0, clnk = 1'h1;
  logic [3:0] cle = 4'h5;
  logic [3:0] c0 = 4'h1, c1 = 4'h2, c2 = 4'h3, c3 = 4'he;
  logic [1:0] ast = 2'h2;
  wire av, aw, ak, im, sc, be, hp, pg, sa, lk;
  wire [1:0] al, ah;
  wire [19:0] aa;
  wire [7:0] ad;
  wire [3:0] le, e0, e1, e2, e3;
  int err_count = 0, tests_run = 0, cyc = 0;
  dsl_aux_peer peer (.clk(clk), .valid(av), .is_write(aw), .acked(ak), .addr(aa), .data(ad));
  dsl_lane_ctrl #(.HOLD_CYCLES(5), .PG_CYCLES(10), .DEBOUNCE_CYCLES(20)) DUT (
    .clk(clk), .sys_rst(sys_rst), .aux_valid(av), .aux_is_write(aw), .aux_acked(ak),
    .aux_addr(aa), .aux_data(ad), .if_sel_strap(sel), .addr_strap_low(ast), .eq_strap_pair(eqs),
    .snoop_disable_pin(snp), .link_enable_pin(lnk), .hot_plug_input(hpd), .cfg_snoop_disable(csnp),
    .cfg_link_enable(clnk), .cfg_lane_enable(cle), .cfg_lane0_eq(c0), .cfg_lane1_eq(c1),
    .cfg_lane2_eq(c2), .cfg_lane3_eq(c3), .power_good(pg), .strap_captured(sc), .bias_enable(be),
    .i2c_mode(im), .addr_level_low(al), .addr_level_high(ah), .snoop_active(sa), .lane_count_cap(),
    .power_state_cap(), .hot_plug_level(hp), .link_enabled(lk), .lane_enable(le),
    .lane0_eq_index(e0), .lane1_eq_index(e1), .lane2_eq_index(e2), .lane3_eq_index(e3));
  ////////////////////////////////////////
  // Clock and hang guard
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end
  task results;
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk1(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk4(input string n, input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Reset with a given interface strap, wait for capture
  task boot(input logic [1:0] s);
    int i;
    @(negedge clk);
    sys_rst = 1'h1;
    sel = s;
    repeat (16) @(negedge clk);
    sys_rst = 1'h0;
    for (i = 0; i < 60 && sc !== 1'h1; i++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask
  // One transaction and the lane mask after it
  task step(input logic w, input logic k, input logic [19:0] a, input logic [7:0] d, input logic [3:0] e);
    peer.xfer(w, k, a, d);
    repeat (3) @(negedge clk);
    chk4("lanes", e, le);
  endtask
  ////////////////////////////////////////
  initial begin
    boot(2'h0);
    chk1("i2c_mode", 1'h0, im);
    chk1("power_good", 1'h1, pg);
    chk4("addr_low", 4'h2, {2'h0, al});
    chk4("addr_high", 4'h1, {2'h0, ah});
    chk4("eq0", 4'h9, e0);
    chk4("eq2", 4'h9, e2);
    chk4("eq3", 4'h9, e3);
    chk4("lanes", 4'hf, le);
    ast = 2'h3;
    repeat (8) @(negedge clk);
    chk1("bias", 1'h0, be);
    chk4("addr_low", 4'h2, {2'h0, al});
    step(1'h1, 1'h1, 20'h00101, 8'h02, 4'h3);
    step(1'h0, 1'h1, 20'h00101, 8'h01, 4'h3);
    step(1'h1, 1'h0, 20'h00101, 8'h01, 4'h3);
    step(1'h1, 1'h1, 20'h00102, 8'h01, 4'h3);
    step(1'h1, 1'h1, 20'h00101, 8'h03, 4'h3);
    step(1'h1, 1'h1, 20'h00101, 8'h01, 4'h1);
    step(1'h1, 1'h1, 20'h00600, 8'h02, 4'h0);
    step(1'h1, 1'h1, 20'h00101, 8'h04, 4'h0);
    step(1'h1, 1'h1, 20'h00600, 8'h01, 4'hf);
    step(1'h1, 1'h1, 20'h00101, 8'h01, 4'h1);
    snp = 1'h1;
    repeat (8) @(negedge clk);
    chk4("lanes", 4'hf, le);
    chk1("snoop", 1'h0, sa);
    snp = 1'h0;
    repeat (8) @(negedge clk);
    chk4("lanes", 4'h1, le);
    lnk = 1'h0;
    hpd = 1'h0;
    repeat (8) @(negedge clk);
    chk4("lanes", 4'h1, le);
    chk1("hot_plug", 1'h1, hp);
    repeat (30) @(negedge clk);
    chk4("lanes", 4'h0, le);
    chk1("link", 1'h0, lk);
    chk1("hot_plug", 1'h0, hp);
    boot(2'h1);
    chk1("i2c_mode", 1'h1, im);
    chk4("addr_low", 4'h3, {2'h0, al});
    chk4("eq0", 4'h1, e0);
    chk4("eq1", 4'h2, e1);
    chk4("eq2", 4'h3, e2);
    chk4("eq3", 4'he, e3);
    c0 = 4'h7;
    repeat (2) @(negedge clk);
    chk4("eq0", 4'h7, e0);
    chk1("snoop", 1'h1, sa);
    csnp = 1'h1;
    repeat (3) @(negedge clk);
    chk4("lanes", 4'h5, le);
    chk1("snoop", 1'h0, sa);
    clnk = 1'h0;
    repeat (3) @(negedge clk);
    chk4("lanes", 4'h0, le);
    chk1("link", 1'h0, lk);
    results();
  end
endmodule // tb
`default_nettype wire
